/* File: design/wscp_baud_gen.v */
// baud tick generator: one-cycle pulse at 16x the selected rate
// assumes sel is stable while a frame is in flight
`timescale 1ns/1ps
`default_nettype none
`include "wscp_defines.vh"
module wscp_baud_gen #(
    parameter integer CLK_HZ = `WSCP_CLK_HZ
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // control
    input  wire       clr,
    input  wire [1:0] sel,
    // tick out
    output reg        tick16
);
    localparam [31:0] DIV_300_W  = CLK_HZ / (`WSCP_BAUD_300 * 16) - 1;
    localparam [31:0] DIV_600_W  = CLK_HZ / (`WSCP_BAUD_600 * 16) - 1;
    localparam [31:0] DIV_1200_W = CLK_HZ / (`WSCP_BAUD_1200 * 16) - 1;
    localparam [31:0] DIV_2400_W = CLK_HZ / (`WSCP_BAUD_2400 * 16) - 1;
    // divider fits 16 bits for any clock up to about 314 MHz
    localparam [15:0] DIV_300    = DIV_300_W[15:0];
    localparam [15:0] DIV_600    = DIV_600_W[15:0];
    localparam [15:0] DIV_1200   = DIV_1200_W[15:0];
    localparam [15:0] DIV_2400   = DIV_2400_W[15:0];

    reg  [15:0] cnt_q;
    reg  [15:0] lim;

    always @* begin
        case (sel)
            `WSCP_BAUD_SEL_300:  lim = DIV_300;
            `WSCP_BAUD_SEL_600:  lim = DIV_600;
            `WSCP_BAUD_SEL_1200: lim = DIV_1200;
            default:             lim = DIV_2400;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 16'h0000;
            tick16 <= 1'b0;
        end else if (clr || cnt_q >= lim) begin
            cnt_q  <= 16'h0000;
            tick16 <= ~clr;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            tick16 <= 1'b0;
        end
    end
endmodule // wscp_baud_gen
`default_nettype wire

/* File: design/wscp_defines.vh */
// constants for the wake-up serial command port
// assumes a 100 MHz system clock; included by bare name
// Behaviour
// - 8N1 framing, raw binary bytes
// - baud 300, 600, 1200 or 2400
// - data bits least significant first
// - reply ACK if valid, else NAK
// - sleep after reply, new wake-up needed
// - transmit command may busy device 3 s
// - no-op command only returns ACK
// - transceiver powered from wake to command end (code powers it with the RS-232 option only)
// - ACK is 0x06, NAK is 0x15
// - two second watchdog sends NAK, sleeps
`ifndef WSCP_DEFINES_VH
`define WSCP_DEFINES_VH

`define WSCP_CLK_HZ        100000000
`define WSCP_ACK_BYTE      8'h06
`define WSCP_NAK_BYTE      8'h15
`define WSCP_NOP_BYTE      8'hB0
`define WSCP_BAUD_SEL_300  2'h0
`define WSCP_BAUD_SEL_600  2'h1
`define WSCP_BAUD_SEL_1200 2'h2
`define WSCP_BAUD_SEL_2400 2'h3
`define WSCP_BAUD_300      300
`define WSCP_BAUD_600      600
`define WSCP_BAUD_1200     1200
`define WSCP_BAUD_2400     2400
`define WSCP_WAKE_MIN_MS   25
`define WSCP_WAKE_MIN_CYC  ((`WSCP_CLK_HZ / 1000) * `WSCP_WAKE_MIN_MS)
`define WSCP_WDOG_S        2
`define WSCP_WDOG_CYC      (`WSCP_CLK_HZ * `WSCP_WDOG_S)
`define WSCP_DATA_BITS     8

`endif

/* File: design/wscp_port.v */
// wake-up serial command port: wake detect, 8N1 receive, ACK/NAK reply
// assumes synchronous pins; host keeps its own spacing and wake timing
`timescale 1ns/1ps
`default_nettype none
`include "wscp_defines.vh"
module wscp_port #(
    parameter integer CLK_HZ       = `WSCP_CLK_HZ,
    parameter integer WAKE_MIN_CYC = `WSCP_WAKE_MIN_CYC,
    parameter integer WDOG_CYC     = `WSCP_WDOG_CYC
) (
    // clock and reset
    input  wire       CLK_SYS,
    input  wire       RST_N,
    // configuration straps
    input  wire [1:0] BAUD_SEL,
    input  wire       OPT_RS232,
    // serial pins (pin polarity per option)
    input  wire       WAKE_PIN,
    input  wire       RXD_PIN,
    output reg        TXD_PIN,
    output reg        XCVR_PWR_EN,
    // command handoff to the rest of the device
    input  wire [3:0] CMD_LEN,
    input  wire       CMD_VALID,
    output reg  [7:0] CMD_BYTE,
    output reg        CMD_BYTE_STB,
    output reg        CMD_DATA_STB,
    output reg  [7:0] CMD_DATA,
    output reg        CMD_DONE,
    output reg        CMD_TIMEOUT,
    output reg        AWAKE
);
    localparam [2:0] S_SLEEP = 3'h0;
    localparam [2:0] S_CMD   = 3'h1;
    localparam [2:0] S_DATA  = 3'h2;
    localparam [2:0] S_TX    = 3'h3;
    localparam [2:0] S_WAIT  = 3'h4;
    localparam [31:0] WAKE_LIM = WAKE_MIN_CYC;
    localparam [31:0] WDOG_LIM = WDOG_CYC;

    reg  [2:0]  st_q;
    reg  [31:0] wake_cnt_q;
    reg  [31:0] wdog_q;
    reg  [3:0]  need_q;
    reg         nak_q;
    reg         wake_armed_q;
    // receiver
    reg         rx_busy_q;
    reg  [3:0]  rx_ph_q;
    reg  [3:0]  rx_bit_q;
    reg  [7:0]  rx_sh_q;
    reg         rx_done_q;
    reg         rx_ferr_q;
    // transmitter
    reg         tx_go_q;
    reg  [7:0]  tx_byte_q;
    reg  [3:0]  tx_ph_q;
    reg  [3:0]  tx_bit_q;
    reg  [9:0]  tx_sh_q;
    reg         tx_busy_q;

    wire        tick16;
    // restart the divider at reply start so the start bit is a full bit
    wire        tx_start = tx_go_q & ~tx_busy_q;
    // pins normalised so that 1 is active wake and 0 is space/start
    wire        wake_act = OPT_RS232 ? WAKE_PIN : ~WAKE_PIN;
    wire        rx_mark  = OPT_RS232 ? ~RXD_PIN : RXD_PIN;
    wire        awake    = (st_q != S_SLEEP);

    wscp_baud_gen #(
        .CLK_HZ (CLK_HZ)
    ) u_baud (
        .clk    (CLK_SYS),
        .rst_n  (RST_N),
        .clr    (tx_start),
        .sel    (BAUD_SEL),
        .tick16 (tick16)
    );

    // wake pulse qualified by minimum width, accepted on return to idle
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            wake_cnt_q   <= 32'h0000_0000;
            wake_armed_q <= 1'b0;
        end else if (wake_act) begin
            if (wake_cnt_q < WAKE_LIM)
                wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
            else
                wake_armed_q <= 1'b1;
        end else begin
            wake_cnt_q   <= 32'h0000_0000;
            wake_armed_q <= 1'b0;
        end
    end
    wire wake_ev = wake_armed_q & ~wake_act & (st_q == S_SLEEP);

    // 8N1 receiver, oversampled 16x, mid-bit sampling
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rx_busy_q <= 1'b0;
            rx_ph_q   <= 4'h0;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 8'h00;
            rx_done_q <= 1'b0;
            rx_ferr_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            if (st_q != S_CMD && st_q != S_DATA) begin
                rx_busy_q <= 1'b0;
            end else if (tick16) begin
                if (!rx_busy_q) begin
                    if (!rx_mark) begin
                        rx_busy_q <= 1'b1;
                        rx_ph_q   <= 4'h0;
                        rx_bit_q  <= 4'h0;
                    end
                end else begin
                    rx_ph_q <= rx_ph_q + 4'h1;
                    if (rx_ph_q == 4'h7) begin
                        if (rx_bit_q == 4'h0 && rx_mark) begin
                            rx_busy_q <= 1'b0; // glitch, not a start bit
                        end else if (rx_bit_q == 4'h9) begin
                            rx_busy_q <= 1'b0;
                            rx_done_q <= 1'b1;
                            rx_ferr_q <= ~rx_mark;
                        end else if (rx_bit_q != 4'h0) begin
                            rx_sh_q <= {rx_mark, rx_sh_q[7:1]};
                        end
                    end
                    if (rx_ph_q == 4'hF)
                        rx_bit_q <= rx_bit_q + 4'h1;
                end
            end
        end
    end

    // 8N1 transmitter
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            tx_busy_q <= 1'b0;
            tx_ph_q   <= 4'h0;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= 10'h3FF;
            TXD_PIN   <= 1'b1;
        end else begin
            if (tx_go_q && !tx_busy_q) begin
                tx_busy_q <= 1'b1;
                tx_sh_q   <= {1'b1, tx_byte_q, 1'b0};
                tx_ph_q   <= 4'h0;
                tx_bit_q  <= 4'h0;
            end else if (tx_busy_q && tick16) begin
                tx_ph_q <= tx_ph_q + 4'h1;
                if (tx_ph_q == 4'hF) begin
                    tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
                    tx_bit_q <= tx_bit_q + 4'h1;
                    if (tx_bit_q == 4'h9)
                        tx_busy_q <= 1'b0;
                end
            end
            // rs-232 inverts; idle mark for both options
            TXD_PIN <= OPT_RS232 ? ~(tx_busy_q ? tx_sh_q[0] : 1'b1)
                                 : (tx_busy_q ? tx_sh_q[0] : 1'b1);
        end
    end

    // command sequencer
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_q         <= S_SLEEP;
            wdog_q       <= 32'h0000_0000;
            need_q       <= 4'h0;
            nak_q        <= 1'b0;
            tx_go_q      <= 1'b0;
            tx_byte_q    <= 8'h00;
            CMD_BYTE     <= 8'h00;
            CMD_BYTE_STB <= 1'b0;
            CMD_DATA     <= 8'h00;
            CMD_DATA_STB <= 1'b0;
            CMD_DONE     <= 1'b0;
            CMD_TIMEOUT  <= 1'b0;
            XCVR_PWR_EN  <= 1'b0;
            AWAKE        <= 1'b0;
        end else begin
            CMD_BYTE_STB <= 1'b0;
            CMD_DATA_STB <= 1'b0;
            CMD_DONE     <= 1'b0;
            CMD_TIMEOUT  <= 1'b0;
            tx_go_q      <= 1'b0;
            AWAKE        <= awake;
            if (st_q == S_CMD || st_q == S_DATA)
                wdog_q <= wdog_q + 32'h0000_0001;
            case (st_q)
                S_SLEEP: if (wake_ev) begin
                    st_q        <= S_CMD;
                    wdog_q      <= 32'h0000_0000;
                    nak_q       <= 1'b0;
                    XCVR_PWR_EN <= OPT_RS232;
                end
                S_CMD, S_DATA: begin
                    if (wdog_q >= WDOG_LIM - 32'h0000_0001) begin
                        st_q        <= S_TX;
                        tx_byte_q   <= `WSCP_NAK_BYTE;
                        CMD_TIMEOUT <= 1'b1;
                    end else if (rx_done_q && st_q == S_CMD) begin
                        nak_q <= rx_ferr_q;
                        if (rx_sh_q == `WSCP_NOP_BYTE) begin
                            st_q <= S_TX;
                            tx_byte_q <= rx_ferr_q ? `WSCP_NAK_BYTE : `WSCP_ACK_BYTE;
                        end else begin
                            CMD_BYTE     <= rx_sh_q;
                            CMD_BYTE_STB <= 1'b1;
                            st_q         <= S_DATA;
                            need_q       <= 4'h0;
                        end
                    end else if (st_q == S_DATA && CMD_BYTE_STB) begin
                        need_q <= CMD_LEN;
                    end else if (st_q == S_DATA && !CMD_BYTE_STB && need_q == 4'h0
                                 && !CMD_DATA_STB) begin
                        CMD_DONE  <= 1'b1;
                        st_q      <= S_TX;
                        tx_byte_q <= (CMD_VALID && !nak_q) ? `WSCP_ACK_BYTE
                                                           : `WSCP_NAK_BYTE;
                    end else if (rx_done_q) begin
                        CMD_DATA     <= rx_sh_q;
                        CMD_DATA_STB <= 1'b1;
                        need_q       <= need_q - 4'h1;
                        if (rx_ferr_q)
                            nak_q <= 1'b1;
                    end
                end
                S_TX: begin
                    tx_go_q <= 1'b1;
                    st_q    <= S_WAIT;
                end
                default: if (!tx_go_q && !tx_busy_q) begin
                    st_q        <= S_SLEEP;
                    XCVR_PWR_EN <= 1'b0;
                end
            endcase
        end
    end
endmodule // wscp_port
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the wake-up serial command port
// host model drives the pins; bench plays the command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic        clk_sys   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [1:0]  baud_sel  = 2'h3;
    logic        opt_rs232 = 1'b0;
    logic [3:0]  cmd_len   = 4'h0;
    logic        cmd_valid = 1'b1;
    logic        pwr_seen  = 1'b0;
    logic [7:0]  rep;
    logic [15:0] seen_data;
    int          n_cmd, n_done, n_to, fails, checked;
    wire logic   wake_pin, rxd_pin, txd_pin, pwr_en, awake;
    wire logic   byte_stb, data_stb, done, tmo;
    wire logic [7:0] cmd_byte, cmd_data;
    // divider base scaled down so all four rates fit the run budget
    wscp_port #(.CLK_HZ(192_000), .WAKE_MIN_CYC(20), .WDOG_CYC(10_000)) dut_u (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .BAUD_SEL(baud_sel), .OPT_RS232(opt_rs232),
        .WAKE_PIN(wake_pin), .RXD_PIN(rxd_pin), .TXD_PIN(txd_pin), .XCVR_PWR_EN(pwr_en),
        .CMD_LEN(cmd_len), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte),
        .CMD_BYTE_STB(byte_stb), .CMD_DATA_STB(data_stb), .CMD_DATA(cmd_data),
        .CMD_DONE(done), .CMD_TIMEOUT(tmo), .AWAKE(awake));
    wscp_host #(.CLK_HZ(192_000)) host_u (.clk(clk_sys), .opt(opt_rs232), .sel(baud_sel),
        .txd(txd_pin),
        .wake(wake_pin), .rxd(rxd_pin));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (byte_stb) n_cmd++;
        if (data_stb) seen_data = {seen_data[7:0], cmd_data};
        if (done) n_done++;
        if (tmo) n_to++;
        if (pwr_en) pwr_seen = 1'b1;
    end
    task automatic tally_and_finish();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic reset_dut(input logic opt);
        rst_n = 1'b0;
        opt_rs232 = opt;
        host_u.cyc(8);
        rst_n = 1'b1;
        host_u.cyc(2);
    endtask
    task automatic got(input logic [7:0] exp);
        host_u.recv(rep);
        `CHK(rep, exp)
        if (host_u.lost) begin
            tally_and_finish();
        end
    endtask
    // reply may start mid stop bit, so listen while still sending
    task automatic command(input logic [7:0] c, input logic [7:0] exp);
        for (int k = 0; k < 5; k++) begin
            host_u.wake_up();
            fork
                begin
                    host_u.send(c);
                    for (int i = 0; i < cmd_len; i++) host_u.send(8'hA0 + i[7:0]);
                end
                host_u.recv(rep);
            join
            host_u.cyc(2000);
            if (!host_u.lost) break;
        end
        `CHK(rep, exp)
        if (host_u.lost) begin
            tally_and_finish();
        end
    endtask
    task automatic t_nop_rates();
        int c0;
        int f0;
        c0 = n_cmd;
        f0 = fails;
        for (int s = 0; s < 4; s++) begin
            baud_sel = s[1:0];
            reset_dut(1'b0);
            command(8'hB0, 8'h06);
            if (fails - f0 > 1) begin
                tally_and_finish();
            end
        end
        `CHK(n_cmd, c0)
    endtask
    task automatic t_store();
        int d0;
        d0 = n_done;
        cmd_len = 4'h2;
        command(8'h12, 8'h06);
        `CHK(cmd_byte, 8'h12)
        `CHK(seen_data, 16'hA0A1)
        `CHK(n_done, d0 + 1)
        cmd_valid = 1'b0;
        command(8'h12, 8'h15);
        cmd_len = 4'h0;
        cmd_valid = 1'b1;
    endtask
    task automatic t_asleep();
        int c0;
        c0 = n_cmd;
        host_u.send(8'h12);
        host_u.cyc(1000);
        `CHK(n_cmd, c0)
        `CHK(txd_pin, 1'b1)
        host_u.wake_up();
        host_u.send(8'h13);
        host_u.cyc(2000);
        `CHK(n_cmd, c0 + 1)
        `CHK(cmd_byte, 8'h13)
    endtask
    task automatic t_timeout();
        int d0;
        int t0;
        d0 = n_done;
        t0 = n_to;
        host_u.wake_up();
        got(8'h15);
        `CHK(n_to, t0 + 1)
        `CHK(n_done, d0)
        host_u.cyc(2000);
        `CHK(awake, 1'b0)
    endtask
    task automatic t_rs232();
        reset_dut(1'b1);
        command(8'h12, 8'h06);
        `CHK(pwr_seen, 1'b1)
        `CHK(pwr_en, 1'b0)
        `CHK(txd_pin, 1'b0)
    endtask
    initial begin
        t_nop_rates();
        t_store();
        t_asleep();
        t_timeout();
        t_rs232();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire

/* File: verif/wscp_host.sv */
// host model: wake pulse, 8N1 bytes out, reply byte in
// assumes CLK_HZ matches the port's divider base; tasks are called from the bench
`timescale 1ns/1ps
`default_nettype none
module wscp_host #(
    parameter integer CLK_HZ = 100_000_000
) (
    // clock and straps
    input  wire logic       clk,
    input  wire logic       opt,
    input  wire logic [1:0] sel,
    // device pins
    input  wire logic       txd,
    output wire logic       wake,
    output wire logic       rxd
);
    logic wake_act = 1'b0;
    logic mark_bit = 1'b1;
    logic lost     = 1'b0;
    assign wake = wake_act ~^ opt;
    assign rxd  = mark_bit ^ opt;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wake_up();
        wake_act = 1'b1;
        cyc(40);
        wake_act = 1'b0;
        cyc(1000);
    endtask
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            mark_bit = f[i];
            cyc(CLK_HZ / (300 << sel));
        end
    endtask
    // bounded hunt for the start bit; lost flags a silent device
    task automatic recv(output logic [7:0] b);
        int n;
        int t;
        t = CLK_HZ / (300 << sel);
        n = 0;
        b = 8'h00;
        // bound covers a whole command at 300 baud and the watchdog
        while ((txd ^ opt) !== 1'b0 && n < 15_000) begin
            cyc(1);
            n++;
        end
        lost = (n >= 15_000);
        if (!lost) begin
            cyc(t / 2);
            for (int i = 0; i < 8; i++) begin
                cyc(t);
                b[i] = txd ^ opt;
            end
            cyc(t);
        end
    endtask
endmodule // wscp_host
`default_nettype wire

/* File: verif/wscp_port_props.sv */
// pin-level assertions for the command port, bound onto wscp_port
// assumes one clock domain and the port's own top-level pins only
`timescale 1ns/1ps
`default_nettype none
`include "wscp_defines.vh"
module wscp_port_props #(
    parameter integer WAKE_MIN_CYC = 20,
    parameter integer WDOG_CYC     = 5000
) (
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    // strap and pins
    input wire logic       OPT_RS232,
    input wire logic       TXD_PIN,
    input wire logic       XCVR_PWR_EN,
    // command handoff
    input wire logic [7:0] CMD_BYTE,
    input wire logic       CMD_BYTE_STB,
    input wire logic       CMD_DATA_STB,
    input wire logic       CMD_DONE,
    input wire logic       CMD_TIMEOUT,
    input wire logic       AWAKE
);
    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    // two asleep cycles: the strap change inside reset has settled
    sequence s_asleep;
        (!AWAKE && $stable(OPT_RS232)) [*2];
    endsequence
    sequence s_byte_held;
        $stable(CMD_BYTE) [*8];
    endsequence
    AST_RX_ONLY_AWAKE: assert property ((CMD_BYTE_STB || CMD_DATA_STB) |-> AWAKE)
        else $error("receive strobe while asleep");
    AST_DONE_ONLY_AWAKE: assert property ((CMD_DONE || CMD_TIMEOUT) |-> AWAKE)
        else $error("command end while asleep");
    AST_TXD_IDLE_ASLEEP: assert property (s_asleep |-> TXD_PIN == !OPT_RS232)
        else $error("txd not idle while asleep");
    AST_PWR_TTL_OFF: assert property (!OPT_RS232 |-> !XCVR_PWR_EN)
        else $error("transceiver powered on ttl option");
    AST_PWR_ON: assert property ((OPT_RS232 && $rose(AWAKE)) |-> ##[0:2] XCVR_PWR_EN)
        else $error("transceiver not powered on wake");
    AST_PWR_OFF: assert property ((OPT_RS232 && $fell(AWAKE)) |-> ##[0:2] !XCVR_PWR_EN)
        else $error("transceiver left on in sleep");
    AST_BYTE_HELD: assert property (CMD_BYTE_STB |-> ##2 s_byte_held)
        else $error("command byte not held");
    AST_NOP_SILENT: assert property (CMD_BYTE_STB |-> ##1 CMD_BYTE != `WSCP_NOP_BYTE)
        else $error("no-op command handed on");
endmodule // wscp_port_props
bind wscp_port wscp_port_props #(
    .WAKE_MIN_CYC(WAKE_MIN_CYC), .WDOG_CYC(WDOG_CYC)
) props_u (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .OPT_RS232(OPT_RS232), .TXD_PIN(TXD_PIN),
    .XCVR_PWR_EN(XCVR_PWR_EN), .CMD_BYTE(CMD_BYTE), .CMD_BYTE_STB(CMD_BYTE_STB),
    .CMD_DATA_STB(CMD_DATA_STB), .CMD_DONE(CMD_DONE), .CMD_TIMEOUT(CMD_TIMEOUT),
    .AWAKE(AWAKE)
);
`default_nettype wire
